// [rtl/usb_otg_ctrl_map.vh]
`ifndef USB_OTG_CTRL_MAP_VH
`define USB_OTG_CTRL_MAP_VH

// Byte addresses
`define ADDR_DEV_CTRL 12'h000
`define ADDR_DEV_IRQ_FLAGS 12'h004
`define ADDR_DEV_IRQ_CLEAR 12'h008
`define ADDR_NAME_WORD2 12'h828
`define ADDR_DRD_STATUS 12'h82C

// Reset values
`define RST_DEV_CTRL 32'h00000100
`define RST_DEV_IRQ_FLAGS 32'h00000000
`define RST_DRD_STATE 4'h9

// Control register fields
`define CTRL_ADDR_LSB 0
`define CTRL_ADDR_MSB 6
`define CTRL_ADDR_EN 7
`define CTRL_DETACH 8
`define CTRL_RWAKE 9
`define CTRL_LOW_SPEED 12

// Flag register fields
`define FLG_SUSPEND 0
`define FLG_SOF 2
`define FLG_END_RESET 3
`define FLG_WAKEUP 4
`define FLG_END_RESUME 5
`define FLG_UP_RESUME 6
`define FLG_EP_LSB 12
`define FLG_EP_MSB 18
`define FLG_DMA_LSB 25
`define FLG_DMA_MSB 30

// Dual-role state encodings
`define ST_A_IDLE 4'h0
`define ST_A_WAIT_VRISE 4'h1
`define ST_A_WAIT_BCON 4'h2
`define ST_A_HOST 4'h3
`define ST_A_SUSPEND 4'h4
`define ST_A_PERIPHERAL 4'h5
`define ST_A_WAIT_VFALL 4'h6
`define ST_A_VBUS_ERR 4'h7
`define ST_A_WAIT_DISCHARGE 4'h8
`define ST_B_IDLE 4'h9
`define ST_B_PERIPHERAL 4'hA
`define ST_B_WAIT_BEGIN_HNP 4'hB
`define ST_B_WAIT_DISCHARGE 4'hC
`define ST_B_WAIT_ACON 4'hD
`define ST_B_HOST 4'hE
`define ST_B_SRP_INIT 4'hF

// Timing
`define CLK_PERIOD_NS 40
`define DISCHARGE_US 100
`define DISCHARGE_CYCLES ((`DISCHARGE_US * 1000) / `CLK_PERIOD_NS)
`define HNP_WAIT_MS 3
`define HNP_WAIT_CYCLES ((`HNP_WAIT_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// [rtl/usb_otg_device_control_status.v]
// Function
// (R1) Second identification word is a fixed read-only constant.
// (R2) State status register holds dual-role state in bits 3:0, resets to 9.
// (R3) State 0 is A idle (id low), 9 is B idle (id high).
// (R4) States 1,2,3: A waits power rise, waits connect, acts as host.
// (R5) States 4,5: A host suspended, A peripheral.
// (R6) States 6,7: A waits power fall, A overcurrent recovery.
// (R7) State 8: A waits 100 us for line discharge.
// (R8) States 10,11: B peripheral, B suspended waits 3 ms before negotiation.
// (R9) States 12,13: B waits discharge, B waits for A connect.
// (R10) States 14,15: B host, B session request attempt.
// (R11) Software writes address field; bus reset clears it.
// (R12) Address enable bit 7: set by write, cleared by bus reset only.
// (R13) Detach bit 8 resets to one and disconnects the pull-up.
// (R14) Remote wake-up bit 9 requests resume; cleared when sent or by bus reset.
// (R15) Low-speed bit 12 selects low speed; clear means full speed.
// (R16) Low-speed bit writable when disabled or frozen; not reset by disable.
// (R17) Flag register resets to zero with fixed bit layout.
// (R18) Address is bits 6:0; unused control bits 31:13 and 11:10 read zero.
// (R19) Suspend flag set after three idle frame periods.
// (R20) Start-of-frame flag set on each detected frame token.
// (R21) Suspend and wake-up flags clear each other when raised.
// (R22) Writing one to the clear register clears a flag; reads zero.
`timescale 1ns/1ns
`include "usb_otg_ctrl_map.vh"

module usb_otg_device_control_status #(
  parameter [31:0] NAME_WORD2 = 32'h00A5C3E1, // Arbitrary identification value
  parameter HNP_WAIT_CYCLES = `HNP_WAIT_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire controller_enable,
  input wire clock_freeze,
  input wire id_pin,
  input wire vbus_valid,
  input wire vbus_session_low,
  input wire vbus_overcurrent,
  input wire peer_connected,
  input wire bus_suspended,
  input wire hnp_requested,
  input wire srp_request,
  input wire bus_reset,
  input wire suspend_detect,
  input wire sof_detect,
  input wire [10:0] sof_frame,
  input wire end_of_reset,
  input wire wakeup_detect,
  input wire end_of_resume,
  input wire resume_sent,
  input wire [6:0] endpoint_irq_flag,
  input wire [5:0] dma_channel_irq_flag,
  output reg [6:0] device_address,
  output reg address_enable,
  output reg detach,
  output reg remote_wakeup_request,
  output reg low_speed_force,
  output reg pullup_connect,
  output reg [10:0] frame_number,
  output reg [3:0] dual_role_state
);

  localparam integer DISCHARGE_INT = `DISCHARGE_CYCLES;
  localparam [16:0] DISCHARGE_CYCLES = DISCHARGE_INT[16:0];

  reg [5:0] event_flags;
  reg [31:0] rd_mux;
  reg [31:0] rdata;
  reg [31:0] next_rdata;
  reg [21:0] timer;
  reg [21:0] next_timer;
  reg [3:0] next_dual_role_state;
  wire discharge_done;
  wire hnp_done;
  wire wr = psel & penable & pwrite;
  wire rd = psel & ~penable & ~pwrite;
  wire clr_wr = wr && (paddr == `ADDR_DEV_IRQ_CLEAR);
  wire ctrl_wr = wr && (paddr == `ADDR_DEV_CTRL);
  wire active = controller_enable & ~clock_freeze;
  wire [31:0] flags_word;
  wire [31:0] ctrl_word;
  wire [31:0] clr_bits = clr_wr ? pwdata : 32'h00000000;

  // Zero wait states; unmapped addresses read zero without error
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata;

  assign ctrl_word = {19'h00000, low_speed_force, 2'h0, remote_wakeup_request,
    detach, address_enable, device_address}; // [R18]
  assign flags_word = {1'b0, dma_channel_irq_flag, 6'h00, endpoint_irq_flag, 5'h00,
    event_flags[5:1], 1'b0, event_flags[0]}; // [R17]

  // Read data is captured in the setup cycle, so prdata comes from a flop with no wait state
  always @* begin
    case (paddr)
      `ADDR_DEV_CTRL: begin
        rd_mux = ctrl_word;
      end
      `ADDR_DEV_IRQ_FLAGS: begin
        rd_mux = flags_word;
      end
      `ADDR_NAME_WORD2: begin
        rd_mux = NAME_WORD2; // [R1]
      end
      `ADDR_DRD_STATUS: begin
        rd_mux = {28'h0000000, dual_role_state}; // [R2]
      end
      default: begin
        rd_mux = 32'h00000000; // [R22]
      end
    endcase
    next_rdata = rd ? rd_mux : rdata;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Control register; low-speed write does not depend on enable or freeze [R16]
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      device_address <= 7'h00;
      address_enable <= 1'b0;
      detach <= 1'b1; // [R13]
      remote_wakeup_request <= 1'b0;
      low_speed_force <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        detach <= pwdata[`CTRL_DETACH]; // [R13]
        low_speed_force <= pwdata[`CTRL_LOW_SPEED]; // [R15] [R16]
      end
      if (bus_reset) begin
        device_address <= 7'h00; // [R11]
        address_enable <= 1'b0; // [R12]
        remote_wakeup_request <= 1'b0; // [R14]
      end else begin
        if (ctrl_wr) begin
          device_address <= pwdata[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB]; // [R11]
        end
        if (ctrl_wr && pwdata[`CTRL_ADDR_EN]) begin
          address_enable <= 1'b1; // [R12]
        end
        if (ctrl_wr && pwdata[`CTRL_RWAKE]) begin
          remote_wakeup_request <= 1'b1; // [R14]
        end else if (resume_sent) begin
          remote_wakeup_request <= 1'b0; // [R14]
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pullup_connect <= 1'b0;
    end else begin
      pullup_connect <= ~detach & controller_enable; // [R13]
    end
  end

  // Event flags: hardware set wins over software clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      event_flags <= 6'h00;
      frame_number <= 11'h000;
    end else begin
      if (wakeup_detect) begin
        event_flags[0] <= 1'b0; // [R21]
      end else if (suspend_detect && active) begin
        event_flags[0] <= 1'b1; // [R19]
      end else if (clr_bits[`FLG_SUSPEND]) begin
        event_flags[0] <= 1'b0; // [R22]
      end
      if (sof_detect && active) begin
        event_flags[1] <= 1'b1; // [R20]
        frame_number <= sof_frame; // [R20]
      end else if (clr_bits[`FLG_SOF]) begin
        event_flags[1] <= 1'b0; // [R22]
      end
      if (end_of_reset && active) begin
        event_flags[2] <= 1'b1;
      end else if (clr_bits[`FLG_END_RESET]) begin
        event_flags[2] <= 1'b0; // [R22]
      end
      // Wake-up is caught even with the clock frozen
      if (wakeup_detect) begin
        event_flags[3] <= 1'b1; // [R21]
      end else if (suspend_detect && active) begin
        event_flags[3] <= 1'b0; // [R21]
      end else if (clr_bits[`FLG_WAKEUP]) begin
        event_flags[3] <= 1'b0; // [R22]
      end
      if (end_of_resume && active) begin
        event_flags[4] <= 1'b1;
      end else if (clr_bits[`FLG_END_RESUME]) begin
        event_flags[4] <= 1'b0; // [R22]
      end
      if (resume_sent && active) begin
        event_flags[5] <= 1'b1;
      end else if (clr_bits[`FLG_UP_RESUME]) begin
        event_flags[5] <= 1'b0; // [R22]
      end
    end
  end

  // Both waits end one count early because the state change itself costs a clock
  assign discharge_done = timer >= {5'h00, DISCHARGE_CYCLES} - 22'h000001; // [R7] [R9]
  assign hnp_done = timer >= HNP_WAIT_CYCLES[21:0] - 22'h000001; // [R8]

  // Dual-role state machine; the timer only runs in the timed states and restarts
  // at zero on entry from an untimed state, so a bounce back cannot shorten it; B wait discharge keeps the HNP wait count
  always @* begin
    next_dual_role_state = dual_role_state;
    next_timer = 22'h000000;
    case (dual_role_state)
      // A side: this end supplies bus power
      `ST_A_IDLE: begin
        if (id_pin) begin
          next_dual_role_state = `ST_B_IDLE; // [R3]
        end else if (srp_request) begin
          next_dual_role_state = `ST_A_WAIT_VRISE; // [R4]
        end
      end
      // Overcurrent wins over every other event while power is applied
      `ST_A_WAIT_VRISE: begin
        if (vbus_overcurrent) begin
          next_dual_role_state = `ST_A_VBUS_ERR; // [R6]
        end else if (vbus_valid) begin
          next_dual_role_state = `ST_A_WAIT_BCON; // [R4]
        end
      end
      `ST_A_WAIT_BCON: begin
        if (vbus_overcurrent) begin
          next_dual_role_state = `ST_A_VBUS_ERR;
        end else if (id_pin) begin
          next_dual_role_state = `ST_A_WAIT_VFALL; // [R6]
        end else if (peer_connected) begin
          next_dual_role_state = `ST_A_HOST; // [R4]
        end
      end
      `ST_A_HOST: begin
        if (vbus_overcurrent) begin
          next_dual_role_state = `ST_A_VBUS_ERR;
        end else if (!peer_connected) begin
          next_dual_role_state = `ST_A_WAIT_BCON;
        end else if (bus_suspended) begin
          next_dual_role_state = `ST_A_SUSPEND; // [R5]
        end
      end
      // A disconnect while suspended hands the host role to the peer
      `ST_A_SUSPEND: begin
        if (vbus_overcurrent) begin
          next_dual_role_state = `ST_A_VBUS_ERR;
        end else if (!peer_connected) begin
          next_dual_role_state = `ST_A_PERIPHERAL; // [R5]
        end else if (!bus_suspended) begin
          next_dual_role_state = `ST_A_HOST;
        end
      end
      `ST_A_PERIPHERAL: begin
        if (vbus_overcurrent) begin
          next_dual_role_state = `ST_A_VBUS_ERR;
        end else if (bus_suspended) begin
          next_dual_role_state = `ST_A_WAIT_BCON;
        end
      end
      `ST_A_WAIT_VFALL: begin
        if (vbus_session_low) begin
          next_dual_role_state = `ST_A_WAIT_DISCHARGE; // [R7]
        end
      end
      `ST_A_VBUS_ERR: begin
        if (!vbus_overcurrent) begin
          next_dual_role_state = `ST_A_WAIT_VFALL; // [R6]
        end
      end
      // The lines must settle before the idle state may sample the id pin again
      `ST_A_WAIT_DISCHARGE: begin
        next_timer = timer + 22'h000001;
        if (discharge_done) begin
          next_dual_role_state = `ST_A_IDLE; // [R7]
        end
      end
      // B side: bus power comes from the peer
      `ST_B_IDLE: begin
        if (!id_pin) begin
          next_dual_role_state = `ST_A_IDLE; // [R3]
        end else if (vbus_valid) begin
          next_dual_role_state = `ST_B_PERIPHERAL; // [R8]
        end else if (srp_request) begin
          next_dual_role_state = `ST_B_SRP_INIT; // [R10]
        end
      end
      `ST_B_PERIPHERAL: begin
        if (!vbus_valid) begin
          next_dual_role_state = `ST_B_IDLE;
        end else if (bus_suspended && hnp_requested) begin
          next_dual_role_state = `ST_B_WAIT_BEGIN_HNP; // [R8]
        end
      end
      // Any bus activity during the wait cancels the role swap
      `ST_B_WAIT_BEGIN_HNP: begin
        next_timer = timer + 22'h000001;
        if (!vbus_valid || !bus_suspended) begin
          next_dual_role_state = `ST_B_PERIPHERAL;
        end else if (hnp_done) begin
          next_dual_role_state = `ST_B_WAIT_DISCHARGE; // [R8] [R9]
        end
      end
      `ST_B_WAIT_DISCHARGE: begin
        next_timer = timer + 22'h000001;
        if (discharge_done) begin
          next_dual_role_state = `ST_B_WAIT_ACON; // [R9]
        end
      end
      `ST_B_WAIT_ACON: begin
        if (!vbus_valid) begin
          next_dual_role_state = `ST_B_IDLE;
        end else if (peer_connected) begin
          next_dual_role_state = `ST_B_HOST; // [R10]
        end
      end
      `ST_B_HOST: begin
        if (!vbus_valid) begin
          next_dual_role_state = `ST_B_IDLE;
        end else if (!peer_connected) begin
          next_dual_role_state = `ST_B_PERIPHERAL;
        end
      end
      // Session request ends when the peer powers the bus or the cable turns us into A
      `ST_B_SRP_INIT: begin
        if (!id_pin) begin
          next_dual_role_state = `ST_A_IDLE;
        end else if (vbus_valid) begin
          next_dual_role_state = `ST_B_PERIPHERAL; // [R10]
        end
      end
      default: begin
        next_dual_role_state = `RST_DRD_STATE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dual_role_state <= `RST_DRD_STATE; // [R2]
      timer <= 22'h000000;
    end else begin
      dual_role_state <= next_dual_role_state;
      timer <= next_timer;
    end
  end

endmodule // usb_otg_device_control_status

// [testbench/usb_otg_device_control_status_props.sv]
`timescale 1ns/1ns
module usb_otg_device_control_status_props #(
  parameter [31:0] NAME_WORD2 = 32'h00000000
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire controller_enable,
  input wire bus_reset,
  input wire resume_sent,
  input wire [6:0] device_address,
  input wire address_enable,
  input wire detach,
  input wire remote_wakeup_request,
  input wire low_speed_force,
  input wire pullup_connect,
  input wire [3:0] dual_role_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd = psel && penable && !pwrite;
  wire ctl_wr = psel && penable && pwrite && paddr == 12'h000;
  wire ls_bit = pwdata[12];
  wire det_bit = pwdata[8];
  property p_addr_clr; bus_reset |=> device_address == 7'h00; endproperty
  a_addr_clr: assert property (p_addr_clr) else $error("address kept");
  property p_aen_hold; address_enable && !bus_reset |=> address_enable; endproperty
  a_aen_hold: assert property (p_aen_hold) else $error("enable lost");
  property p_rwk_clr; resume_sent || bus_reset |=> !remote_wakeup_request; endproperty
  a_rwk_clr: assert property (p_rwk_clr) else $error("wakeup kept");
  property p_pullup;
    pullup_connect == (!$past(detach) && $past(controller_enable));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup wrong");
  property p_ctl_wr;
    ctl_wr |=> low_speed_force == $past(ls_bit) && detach == $past(det_bit);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control bits wrong");
  property p_name; rd && paddr == 12'h828 |-> prdata == NAME_WORD2; endproperty
  a_name: assert property (p_name) else $error("name word wrong");
  property p_state;
    rd && paddr == 12'h82C |-> prdata == {28'h0000000, $past(dual_role_state)};
  endproperty
  a_state: assert property (p_state) else $error("state read wrong");
  property p_rsv;
    rd && paddr == 12'h000 |-> prdata[31:13] == 19'h00000 && prdata[11:10] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("unused bits set");
  c_reset: cover property (bus_reset);
  c_write: cover property (ctl_wr);
  c_resume: cover property (resume_sent);
endmodule // usb_otg_device_control_status_props

bind usb_otg_device_control_status usb_otg_device_control_status_props #(
  .NAME_WORD2(NAME_WORD2)) u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .controller_enable(controller_enable), .bus_reset(bus_reset), .resume_sent(resume_sent),
  .device_address(device_address), .address_enable(address_enable), .detach(detach),
  .remote_wakeup_request(remote_wakeup_request), .low_speed_force(low_speed_force),
  .pullup_connect(pullup_connect), .dual_role_state(dual_role_state));

// [testbench/usb_peer_model.sv]
`timescale 1ns/1ns
module usb_peer_model (
  input wire clk,
  output wire bus_reset,
  output wire suspend_detect,
  output wire sof_detect,
  output wire end_of_reset,
  output wire wakeup_detect,
  output wire end_of_resume,
  output wire resume_sent,
  output reg [10:0] sof_frame
);
  reg [6:0] ev = 7'h00;
  assign {resume_sent, end_of_resume, wakeup_detect, end_of_reset, sof_detect,
    suspend_detect, bus_reset} = ev;
  initial sof_frame = 11'h7FF;
  // Frame number is only meaningful beside its token; scrambled otherwise
  task send(input [6:0] code, input [10:0] frame);
    begin
      @(posedge clk);
      ev <= code;
      sof_frame <= frame;
      @(posedge clk);
      ev <= 7'h00;
      sof_frame <= ~frame;
    end
  endtask
endmodule // usb_peer_model

// [testbench/test_usb_otg_device_control_status.sv]
`timescale 1ns/1ns
module test_usb_otg_device_control_status;
  localparam [31:0] NAME = 32'h0F1E2D3C; // Arbitrary identification value
  reg clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg en = 1'b1, frz = 1'b0, id_pin = 1'b1, hnp = 1'b0, srp = 1'b0, vbus = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [6:0] ep = 7'h00;
  reg [5:0] dma = 6'h00;
  reg [31:0] q;
  wire [31:0] prdata;
  wire [10:0] sfr, fnum;
  wire pready, pull, br, sus, sof, eor, wk, ers, rs;
  integer err_total = 0;
  integer checked = 0;
  usb_otg_device_control_status #(.NAME_WORD2(NAME), .HNP_WAIT_CYCLES(20)) u_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .controller_enable(en), .clock_freeze(frz), .id_pin(id_pin), .vbus_valid(vbus),
    .vbus_session_low(1'b0), .vbus_overcurrent(1'b0), .peer_connected(1'b0),
    .bus_suspended(1'b0), .hnp_requested(hnp), .srp_request(srp), .bus_reset(br),
    .suspend_detect(sus), .sof_detect(sof), .sof_frame(sfr), .end_of_reset(eor),
    .wakeup_detect(wk), .end_of_resume(ers), .resume_sent(rs),
    .endpoint_irq_flag(ep), .dma_channel_irq_flag(dma), .device_address(),
    .address_enable(), .detach(), .remote_wakeup_request(), .low_speed_force(),
    .pullup_connect(pull), .frame_number(fnum), .dual_role_state());
  usb_peer_model u_peer (.clk(clk), .bus_reset(br), .suspend_detect(sus), .sof_detect(sof),
    .end_of_reset(eor), .wakeup_detect(wk), .end_of_resume(ers), .resume_sent(rs),
    .sof_frame(sfr));
  initial forever #20 clk = ~clk;
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h00000000);
      chk($sformatf("reg %h", a), q, e);
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rc(12'h000, 32'h00000100);
    rc(12'h004, 32'h00000000);
    rc(12'h828, NAME);
    rc(12'h82C, 32'h00000009);
    chk("pullup", {31'h0, pull}, 32'h00000000);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    rc(12'h010, 32'h00000000);
    $display("test reset_values done");
    apb(1'b1, 12'h000, 32'hFFFFFED5);
    rc(12'h000, 32'h000012D5);
    chk("pullup", {31'h0, pull}, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000000);
    rc(12'h000, 32'h00000280);
    u_peer.send(7'h40, 11'h000);
    rc(12'h000, 32'h00000080);
    apb(1'b1, 12'h000, 32'h000002D5);
    u_peer.send(7'h01, 11'h000);
    rc(12'h000, 32'h00000000);
    apb(1'b1, 12'h000, 32'h00000100);
    repeat (2) @(posedge clk);
    chk("pullup", {31'h0, pull}, 32'h00000000);
    en <= 1'b0;
    frz <= 1'b1;
    apb(1'b1, 12'h000, 32'h00001100);
    en <= 1'b1;
    frz <= 1'b0;
    rc(12'h000, 32'h00001100);
    apb(1'b1, 12'h000, 32'h00000000);
    rc(12'h000, 32'h00000000);
    $display("test control done");
    ep <= 7'h7F;
    dma <= 6'h3F;
    u_peer.send(7'h6C, 11'h2AB);
    @(negedge clk);
    chk("frame", {21'h0, fnum}, 32'h000002AB);
    u_peer.send(7'h02, 11'h000);
    rc(12'h004, 32'h7E07F06D);
    u_peer.send(7'h10, 11'h000);
    rc(12'h004, 32'h7E07F07C);
    u_peer.send(7'h02, 11'h000);
    rc(12'h004, 32'h7E07F06D);
    apb(1'b1, 12'h008, 32'h0000007D);
    rc(12'h004, 32'h7E07F000);
    rc(12'h008, 32'h00000000);
    ep <= 7'h00;
    dma <= 6'h00;
    repeat (2) @(posedge clk);
    rc(12'h004, 32'h00000000);
    $display("test flags done");
    id_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rc(12'h82C, 32'h00000000);
    id_pin <= 1'b1;
    repeat (3) @(posedge clk);
    rc(12'h82C, 32'h00000009);
    srp <= 1'b1;
    hnp <= 1'b1;
    repeat (30) @(posedge clk);
    rc(12'h82C, 32'h0000000F);
    srp <= 1'b0;
    hnp <= 1'b0;
    vbus <= 1'b1;
    repeat (3) @(posedge clk);
    rc(12'h82C, 32'h0000000A);
    vbus <= 1'b0;
    repeat (3) @(posedge clk);
    rc(12'h82C, 32'h00000009);
    $display("test state done");
    complete_run;
  end
endmodule // test_usb_otg_device_control_status
